//--- core/wdog_top.sv
// module: watchdog timer with secure clear, AXI4-Lite register slave
//
// Behaviour
// - control bit 5 set enters watchdog mode; clear (default) is normal mode.
// - watchdog mode counts down from the load value to zero.
// - watchdog counter is clocked by the 32 kHz source through the prescaler.
// - at zero, reset request if control bit 1 clear, else interrupt.
// - watchdog mode without secure clear: any clear write reloads the counter.
// - in watchdog mode load and control writes are ignored until reset.
// - counter is 16 bits; the value register reads the present count.
// - in normal mode control bit 8 set counts up, clear counts down.
// - control bit 7 enables counting in normal mode; disabled after reset.
// - in normal mode control bit 6 selects periodic reload, clear selects free running.
// - control bit 4 enables secure clear, effective only in watchdog mode.
// - bits 3:2 pick divide 1, 16 or 256; code 11 acts as 00.
// - normal mode uses the same 32 kHz source and prescaler.
// - normal mode: any clear write drops the pending timer interrupt.
// - secure values come from an 8-bit LFSR, x^8+x^6+x^5+x+1.
// - clear write before watchdog mode seeds the LFSR as first expected value.
// - matching secure write reloads the counter and steps the LFSR.
// - mismatching secure write requests a reset at once.
// - a zero seed makes every secure clear write mismatch and request a reset.
// - the LFSR state is never readable through any register.
//
// The implementer's own choice: the AXI4-Lite register port.
module wdog_top (
  input wire logic REF_CLK_I,                    // 40 MHz reference clock
  input wire logic RESET_I,                      // synchronous reset, active high
  input wire logic AWVALID_I,                    // write address valid
  output logic AWREADY_O,                        // write address ready
  input wire wdog_pkg::axi_addr_t AW_I,          // write address payload
  input wire logic WVALID_I,                     // write data valid
  output logic WREADY_O,                         // write data ready
  input wire wdog_pkg::axi_wdata_t W_I,          // write data payload
  output logic BVALID_O,                         // write response valid
  input wire logic BREADY_I,                     // write response ready
  output logic [1:0] BRESP_O,                    // write response code
  input wire logic ARVALID_I,                    // read address valid
  output logic ARREADY_O,                        // read address ready
  input wire wdog_pkg::axi_addr_t AR_I,          // read address payload
  output logic RVALID_O,                         // read data valid
  input wire logic RREADY_I,                     // read data ready
  output wdog_pkg::axi_rdata_t R_O,              // read data payload
  output logic WDOG_RESET_O,                     // reset request pulse
  output logic TIMER_IRQ_O                       // pending timer interrupt
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] timeout_load;
  logic [15:0] watchdog_control;
  logic [15:0] count_value;
  logic [7:0] lfsr;
  logic [7:0] lfsr_next;
  logic tick;
  logic aw_full;
  logic w_full;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;

  // decoded control
  logic wd_mode;
  logic run;
  logic count_down;
  logic periodic;
  logic irq_opt;
  logic secure;
  logic at_end;
  logic expire;

  // register write strobes
  logic load_wr;
  logic ctrl_wr;
  logic clear_wr;
  logic enter_wd;
  logic seed_wr;
  logic secure_match;
  logic secure_fail;
  logic service_reload;
  logic next_reset_req;
  logic [15:0] ctrl_merged;

  // derived events
  logic [15:0] end_value;
  logic service_step;
  logic wd_timeout;
  logic irq_set;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge of a 16-bit register with write strobes
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction : merge16

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  // same source and prescaler serve both modes
  wdog_tick_divider u_tick (
    .clk_i(REF_CLK_I),
    .reset_i(RESET_I),
    .sel_i(watchdog_control[wdog_pkg::CTL_PRE_HI:wdog_pkg::CTL_PRE_LO]),
    .tick_o(tick)
  );

  // next expected value stands ready for the step on an accepted service
  wdog_lfsr_step u_lfsr (
    .state_i(lfsr),
    .next_o(lfsr_next)
  );

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // address and data are taken independently, in either order
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      aw_full <= 1'b0;
      wr_addr <= 32'h0000_0000;
      AWREADY_O <= 1'b1;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_full <= 1'b1;
      wr_addr <= AW_I.addr;
      AWREADY_O <= 1'b0;
    end else if (BVALID_O && BREADY_I) begin
      aw_full <= 1'b0;
      AWREADY_O <= 1'b1;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      w_full <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      WREADY_O <= 1'b1;
    end else if (WVALID_I && WREADY_O) begin
      w_full <= 1'b1;
      wr_data <= W_I.data;
      wr_strb <= W_I.strb;
      WREADY_O <= 1'b0;
    end else if (BVALID_O && BREADY_I) begin
      w_full <= 1'b0;
      WREADY_O <= 1'b1;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  // the write acts in the cycle both halves are held
  assign wr_fire = aw_full && w_full && !BVALID_O;
  // every mapped offset answers OKAY, even where the write is dropped
  assign wr_hit = (wr_addr == wdog_pkg::ADDR_TIMEOUT_LOAD) ||
                  (wr_addr == wdog_pkg::ADDR_COUNT_VALUE) ||
                  (wr_addr == wdog_pkg::ADDR_WATCHDOG_CONTROL) ||
                  (wr_addr == wdog_pkg::ADDR_SERVICE_CLEAR);

  // response; writes to the read-only value register are dropped but answered
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      BVALID_O <= 1'b0;
      BRESP_O <= wdog_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      BVALID_O <= 1'b1;
      BRESP_O <= wr_hit ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  // expected secure value is deliberately absent from every read word
  always_comb begin
    rd_hit = 1'b1;
    unique case (AR_I.addr)
      wdog_pkg::ADDR_TIMEOUT_LOAD: rd_word = {16'h0000, timeout_load};
      wdog_pkg::ADDR_COUNT_VALUE: rd_word = {16'h0000, count_value};
      wdog_pkg::ADDR_WATCHDOG_CONTROL: rd_word = {16'h0000, watchdog_control};
      wdog_pkg::ADDR_SERVICE_CLEAR: rd_word = 32'h0000_0000;
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read outstanding; data registered one cycle after the address
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      R_O <= '0;
    end else if (ARVALID_I && ARREADY_O) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      R_O.data <= rd_word;
      R_O.resp <= rd_hit ? wdog_pkg::RESP_OKAY : wdog_pkg::RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // control decode
  // ----------------------------------------
  assign wd_mode = watchdog_control[wdog_pkg::CTL_WDOG_MODE];
  // watchdog always runs downward; normal mode obeys enable and direction
  assign run = wd_mode || watchdog_control[wdog_pkg::CTL_ENABLE];
  assign count_down = wd_mode || !watchdog_control[wdog_pkg::CTL_COUNT_UP];
  assign periodic = watchdog_control[wdog_pkg::CTL_PERIODIC];
  assign irq_opt = watchdog_control[wdog_pkg::CTL_IRQ_OPT];
  assign secure = wd_mode && watchdog_control[wdog_pkg::CTL_SECURE];
  // free running wraps from one end of the range to the other
  assign end_value = count_down ? 16'h0000 : 16'hFFFF;
  assign at_end = (count_value == end_value);
  assign expire = tick && run && at_end;

  // write decode; protected registers go quiet once watchdog mode is on
  assign load_wr = wr_fire && !wd_mode && (wr_addr == wdog_pkg::ADDR_TIMEOUT_LOAD);
  assign ctrl_wr = wr_fire && !wd_mode && (wr_addr == wdog_pkg::ADDR_WATCHDOG_CONTROL);
  assign clear_wr = wr_fire && wr_strb[0] && (wr_addr == wdog_pkg::ADDR_SERVICE_CLEAR);
  assign ctrl_merged = merge16(watchdog_control, wr_data, wr_strb) & wdog_pkg::CTL_WRITE_MASK;
  assign enter_wd = ctrl_wr && ctrl_merged[wdog_pkg::CTL_WDOG_MODE];

  // service check; an all-zero expected value can never be matched
  assign seed_wr = clear_wr && !wd_mode;
  assign secure_match = (wr_data[7:0] == lfsr) && (lfsr != wdog_pkg::LFSR_ZERO);
  assign secure_fail = clear_wr && secure && !secure_match;
  assign service_reload = clear_wr && wd_mode && (!secure || secure_match);
  assign service_step = clear_wr && secure && secure_match;

  // ----------------------------------------
  // registers written by software
  // ----------------------------------------
  // load value is taken as the timeout on entry, so it must be set first
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      timeout_load <= wdog_pkg::RST_TIMEOUT_LOAD;
    end else if (load_wr) begin
      timeout_load <= merge16(timeout_load, wr_data, wr_strb);
    end
  end

  // only a system reset can leave watchdog mode
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      watchdog_control <= wdog_pkg::RST_WATCHDOG_CONTROL;
    end else if (ctrl_wr) begin
      watchdog_control <= ctrl_merged;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // service and entry reload beat a tick in the same cycle
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      count_value <= wdog_pkg::RST_COUNT_VALUE;
    end else if (enter_wd || service_reload) begin
      count_value <= timeout_load;
    end else if (tick && run) begin
      if (at_end) begin
        if (wd_mode || periodic) begin
          count_value <= timeout_load;
        end else begin
          count_value <= ~end_value;
        end
      end else if (count_down) begin
        count_value <= count_value - 16'h0001;
      end else begin
        count_value <= count_value + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // secure clear sequence
  // ----------------------------------------
  // seed before entry, step only on an accepted service
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      lfsr <= wdog_pkg::RST_SERVICE_CLEAR;
    end else if (seed_wr) begin
      lfsr <= wr_data[7:0];
    end else if (service_step) begin
      lfsr <= lfsr_next;
    end
  end

  // ----------------------------------------
  // outputs to the system
  // ----------------------------------------
  // interrupt flag: a new expiry in the clearing cycle stays pending
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      TIMER_IRQ_O <= 1'b0;
    end else if (irq_set) begin
      TIMER_IRQ_O <= 1'b1;
    end else if (clear_wr) begin
      TIMER_IRQ_O <= 1'b0;
    end
  end

  // expiry gives either a reset request or an interrupt, never both
  assign wd_timeout = expire && wd_mode && !irq_opt;
  assign irq_set = expire && (!wd_mode || irq_opt);

  // reset request is registered, so it lands one cycle after the cause
  assign next_reset_req = wd_timeout || secure_fail;

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      WDOG_RESET_O <= 1'b0;
    end else begin
      WDOG_RESET_O <= next_reset_req;
    end
  end
endmodule : wdog_top

//--- core/wdog_pkg.sv
// package: register map, field positions, timing and bus payload types of the watchdog
package wdog_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_TIMEOUT_LOAD = 32'hFFFF_0360;
  localparam logic [31:0] ADDR_COUNT_VALUE = 32'hFFFF_0364;
  localparam logic [31:0] ADDR_WATCHDOG_CONTROL = 32'hFFFF_0368;
  localparam logic [31:0] ADDR_SERVICE_CLEAR = 32'hFFFF_036C;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_TIMEOUT_LOAD = 16'h0000;
  localparam logic [15:0] RST_COUNT_VALUE = 16'hFFFF;
  localparam logic [15:0] RST_WATCHDOG_CONTROL = 16'h0000;
  localparam logic [7:0] RST_SERVICE_CLEAR = 8'h00;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int CTL_COUNT_UP = 8;
  localparam int CTL_ENABLE = 7;
  localparam int CTL_PERIODIC = 6;
  localparam int CTL_WDOG_MODE = 5;
  localparam int CTL_SECURE = 4;
  localparam int CTL_PRE_HI = 3;
  localparam int CTL_PRE_LO = 2;
  localparam int CTL_IRQ_OPT = 1;
  // writable control bits; 15:9 and 0 are reserved and read as zero
  localparam logic [15:0] CTL_WRITE_MASK = 16'h01FE;
  // ----------------------------------------
  // prescaler codes and counts
  // ----------------------------------------
  localparam logic [1:0] PRE_DIV1 = 2'b00;
  localparam logic [1:0] PRE_DIV16 = 2'b01;
  localparam logic [1:0] PRE_DIV256 = 2'b10;
  localparam logic [7:0] PRE16_LAST = 8'h0F;
  localparam logic [7:0] PRE256_LAST = 8'hFF;
  // ----------------------------------------
  // timing: 32 kHz source derived from the 40 MHz reference
  // ----------------------------------------
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int SRC_CLK_HZ = 32_768;
  localparam int SRC_DIV_CYCLES = REF_CLK_HZ / SRC_CLK_HZ;
  localparam logic [10:0] SRC_DIV_LAST = 11'(SRC_DIV_CYCLES - 1);
  // ----------------------------------------
  // secure clear sequence generator
  // ----------------------------------------
  localparam logic [7:0] LFSR_TAPS = 8'h63;
  localparam logic [7:0] LFSR_ZERO = 8'h00;
  // ----------------------------------------
  // bus payloads
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] prot;
  } axi_addr_t;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } axi_wdata_t;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } axi_rdata_t;
endpackage : wdog_pkg

//--- core/wdog_tick_divider.sv
// module: 32 kHz source enable and selectable 1/16/256 prescale enable
module wdog_tick_divider (
  input wire logic clk_i,         // reference clock
  input wire logic reset_i,       // synchronous reset, active high
  input wire logic [1:0] sel_i,   // prescale code
  output logic tick_o             // one-cycle counter enable
);
  logic [10:0] src_cnt;
  logic src_tick;
  logic [7:0] pre_cnt;

  // base divider makes the 32 kHz source as a one-cycle enable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      src_cnt <= 11'h000;
      src_tick <= 1'b0;
    end else begin
      src_tick <= (src_cnt == wdog_pkg::SRC_DIV_LAST);
      if (src_cnt == wdog_pkg::SRC_DIV_LAST) begin
        src_cnt <= 11'h000;
      end else begin
        src_cnt <= src_cnt + 11'h001;
      end
    end
  end

  // prescale counter runs free so a code change needs no restart
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_cnt <= 8'h00;
    end else if (src_tick) begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // code 11 falls into the divide-by-one branch
  always_comb begin
    unique case (sel_i)
      wdog_pkg::PRE_DIV16: tick_o = src_tick && (pre_cnt[3:0] == wdog_pkg::PRE16_LAST[3:0]);
      wdog_pkg::PRE_DIV256: tick_o = src_tick && (pre_cnt == wdog_pkg::PRE256_LAST);
      default: tick_o = src_tick;
    endcase
  end
endmodule : wdog_tick_divider

//--- core/wdog_lfsr_step.sv
// module: one step of the 8-bit service sequence generator
module wdog_lfsr_step (
  input wire logic [7:0] state_i,  // present expected value
  output logic [7:0] next_o        // following expected value
);
  // shift left, fold taps in when the top bit falls out
  always_comb begin
    next_o = {state_i[6:0], 1'b0} ^ (state_i[7] ? wdog_pkg::LFSR_TAPS : 8'h00);
  end
endmodule : wdog_lfsr_step

//--- verification/wdog_chk.sv
// checker: bus timing, reset request and interrupt relations at the watchdog ports
module wdog_chk (
  input wire logic REF_CLK_I,              // reference clock
  input wire logic RESET_I,                // synchronous reset
  input wire logic AWVALID_I,              // write address valid
  input wire logic AWREADY_O,              // write address ready
  input wire wdog_pkg::axi_addr_t AW_I,    // write address payload
  input wire logic WVALID_I,               // write data valid
  input wire logic WREADY_O,               // write data ready
  input wire wdog_pkg::axi_wdata_t W_I,    // write data payload
  input wire logic BVALID_O,               // write response valid
  input wire logic BREADY_I,               // write response ready
  input wire logic [1:0] BRESP_O,          // write response code
  input wire logic ARVALID_I,              // read address valid
  input wire logic ARREADY_O,              // read address ready
  input wire wdog_pkg::axi_addr_t AR_I,    // read address payload
  input wire logic RVALID_O,               // read data valid
  input wire logic RREADY_I,               // read data ready
  input wire wdog_pkg::axi_rdata_t R_O,    // read data payload
  input wire logic WDOG_RESET_O,           // reset request pulse
  input wire logic TIMER_IRQ_O             // pending interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] aw_addr;
  logic [31:0] ar_addr;
  logic rd_reg;
  logic rd_hole;
  // ----------------------------------------
  // address capture
  // ----------------------------------------
  // addresses leave the bus after acceptance, so keep them for the answer
  always_ff @(posedge REF_CLK_I) begin
    if (AWVALID_I && AWREADY_O) aw_addr <= AW_I.addr;
    if (ARVALID_I && ARREADY_O) ar_addr <= AR_I.addr;
  end
  // readable registers and holes in the map
  assign rd_reg = ar_addr inside {wdog_pkg::ADDR_TIMEOUT_LOAD, wdog_pkg::ADDR_COUNT_VALUE,
                                  wdog_pkg::ADDR_WATCHDOG_CONTROL};
  assign rd_hole = !rd_reg && (ar_addr != wdog_pkg::ADDR_SERVICE_CLEAR);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence s_b_answer;
    ##1 !BVALID_O ##1 BVALID_O;
  endsequence
  a_b_latency: assert property (s_wr_taken |-> s_b_answer)
    else $error("write response not two cycles after write taken");
  a_r_latency: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read data not one cycle after read taken");
  a_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped before taken");
  a_r_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(R_O))
    else $error("read data dropped before taken");
  a_ar_blocked: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read address accepted while data pending");
  a_hole_error: assert property ($rose(RVALID_O) && rd_hole |->
    R_O.resp == wdog_pkg::RESP_SLVERR && R_O.data == 32'h0000_0000)
    else $error("unmapped read not answered with error");
  a_upper_zero: assert property ($rose(RVALID_O) && rd_reg |->
    R_O.data[31:16] == 16'h0000 && R_O.resp == wdog_pkg::RESP_OKAY)
    else $error("register read with nonzero upper half");
  a_pulse_once: assert property (WDOG_RESET_O |=> !WDOG_RESET_O)
    else $error("reset request longer than one cycle");
  a_irq_clear: assert property ($fell(TIMER_IRQ_O) |->
    $rose(BVALID_O) && aw_addr == wdog_pkg::ADDR_SERVICE_CLEAR)
    else $error("interrupt dropped without a clear write");
endmodule : wdog_chk

//--- verification/reset_sink.sv
// partner model: system reset logic that tallies watchdog reset request cycles
module reset_sink (
  input wire logic clk_i,   // reference clock
  input wire logic req_i,   // reset request from the watchdog
  output int high_o         // cycles seen with the request high
);
  timeunit 1ns;
  timeprecision 100ps;
  // kept across system resets, so the bench can total every request
  initial high_o = 0;
  always @(posedge clk_i) if (req_i === 1'b1) high_o <= high_o + 1;
endmodule : reset_sink

//--- verification/testbench.sv
// testbench: register access, timer expiry, watchdog service and secure clear
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] LD = wdog_pkg::ADDR_TIMEOUT_LOAD;
  localparam logic [31:0] VAL = wdog_pkg::ADDR_COUNT_VALUE;
  localparam logic [31:0] CTL = wdog_pkg::ADDR_WATCHDOG_CONTROL;
  localparam logic [31:0] CLR = wdog_pkg::ADDR_SERVICE_CLEAR;
  localparam logic [1:0] OK = wdog_pkg::RESP_OKAY;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, wdog_rst, irq;
  logic [1:0] bresp;
  wdog_pkg::axi_addr_t aw, ar;
  wdog_pkg::axi_wdata_t w;
  wdog_pkg::axi_rdata_t r;
  logic [33:0] expq[$];
  logic [31:0] d;
  int n_mismatch = 0, n_compared = 0, seed = 32'h39ccb7eb, n_high, mark;
  logic [7:0] svc_seq [3] = '{8'hAA, 8'h37, 8'h6E};
  wdog_top i_dut (.REF_CLK_I(clk), .RESET_I(rst), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .AW_I(aw), .WVALID_I(wvalid), .WREADY_O(wready), .W_I(w), .BVALID_O(bvalid),
    .BREADY_I(bready), .BRESP_O(bresp), .ARVALID_I(arvalid), .ARREADY_O(arready), .AR_I(ar),
    .RVALID_O(rvalid), .RREADY_I(rready), .R_O(r), .WDOG_RESET_O(wdog_rst), .TIMER_IRQ_O(irq));
  reset_sink i_sink (.clk_i(clk), .req_i(wdog_rst), .high_o(n_high));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function logic [33:0] ev(input logic [15:0] v);
    return {16'h0000, v, OK};
  endfunction : ev
  // both channels offered together, each held until its ready
  task wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] e);
    bit aw_on, w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw <= {a, 3'($random(seed))};
    w <= {v, 4'hF};
    while (aw_on || w_on) begin
      @(posedge clk);
      if (awready === 1'b1) aw_on = 1'b0;
      if (wready === 1'b1) w_on = 1'b0;
      awvalid <= aw_on;
      wvalid <= w_on;
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", {32'h0, bresp}, {32'h0, e});
  endtask : wr
  // expected read result goes to the queue; the monitor compares it
  task rd(input logic [31:0] a, input logic [33:0] e);
    @(posedge clk);
    arvalid <= 1'b1;
    ar <= {a, 3'b000};
    expq.push_back(e);
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // watch reset request or interrupt for a span of cycles
  task watch(input int cyc, input logic e, input bit on_irq);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      if ((on_irq ? irq : wdog_rst) === 1'b1) seen = 1'b1;
    end
    check(on_irq ? "interrupt" : "reset request", {33'h0, seen}, {33'h0, e});
  endtask : watch
  task sys_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask : sys_reset
  task stop_test();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // read monitor: oldest note against each read answer
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (expq.size() == 0) check("unexpected read", r, 34'h0);
      else check("read data", r, expq.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog: whole plan takes about 35000 cycles
  initial begin
    #(25ns * 60000);
    n_mismatch++;
    stop_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    aw = '0;
    ar = '0;
    w = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(LD, ev(16'h0000));
    rd(CTL, ev(16'h0000));
    rd(32'hFFFF_0370, {32'h0, wdog_pkg::RESP_SLVERR});
    wr(32'hFFFF_0370, 32'h1, wdog_pkg::RESP_SLVERR);
    // reserved bits stay zero; enable kept off so the count holds
    wr(CTL, 32'hFFFF_FF5F, OK);
    rd(CTL, ev(16'h015E));
    for (int c = 0; c < 4; c++) begin
      wr(CTL, 32'(c) << 2, OK);
      rd(CTL, ev(16'(c) << 2));
    end
    d = $random(seed);
    wr(LD, d, OK);
    rd(LD, ev(d[15:0]));
    wr(VAL, ~d, OK);
    rd(VAL, ev(16'hFFFF));
    // normal mode counting up from the top expires at the first tick
    wr(LD, 32'h5, OK);
    wr(CTL, 32'h1C0, OK);
    watch(1300, 1'b1, 1'b1);
    wr(CLR, $random(seed), OK);
    check("interrupt after clear", {33'h0, irq}, 34'h0);
    wr(CTL, 32'h0, OK);
    // plain watchdog: load first, then enable; service keeps it quiet
    sys_reset();
    wr(LD, 32'h2, OK);
    wr(CTL, 32'h20, OK);
    wr(LD, 32'hFF, OK);
    wr(CTL, 32'h0, OK);
    rd(LD, ev(16'h0002));
    rd(CTL, ev(16'h0020));
    repeat (4) begin
      watch(1500, 1'b0, 1'b0);
      wr(CLR, $random(seed), OK);
    end
    watch(3700, 1'b1, 1'b0);
    // interrupt option replaces the reset request
    sys_reset();
    wr(LD, 32'h0, OK);
    wr(CTL, 32'h22, OK);
    watch(1300, 1'b1, 1'b1);
    // divide by 16 is slower than one source period; code 11 is not
    sys_reset();
    wr(LD, 32'h0, OK);
    wr(CTL, 32'h24, OK);
    watch(1300, 1'b0, 1'b0);
    watch(20000, 1'b1, 1'b0);
    sys_reset();
    wr(LD, 32'h0, OK);
    wr(CTL, 32'h2C, OK);
    watch(1300, 1'b1, 1'b0);
    // secure clear: seeded sequence then a wrong value
    sys_reset();
    wr(CLR, 32'hAA, OK);
    wr(LD, 32'h8, OK);
    wr(CTL, 32'h30, OK);
    foreach (svc_seq[i]) begin
      wr(CLR, {24'h0, svc_seq[i]}, OK);
      watch(5, 1'b0, 1'b0);
    end
    // the pulse stands with the write response, before the watch starts
    mark = n_high;
    wr(CLR, 32'h66, OK);
    watch(5, 1'b0, 1'b0);
    check("mismatch reset", 34'(n_high - mark), 34'd1);
    // zero seed is never accepted
    sys_reset();
    wr(CLR, 32'h0, OK);
    wr(LD, 32'h8, OK);
    wr(CTL, 32'h30, OK);
    mark = n_high;
    wr(CLR, 32'h0, OK);
    watch(5, 1'b0, 1'b0);
    check("zero seed reset", 34'(n_high - mark), 34'd1);
    check("reset request cycles", 34'(n_high), 34'd5);
    stop_test();
  end
endmodule : testbench

bind wdog_top wdog_chk i_chk (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .AW_I(AW_I), .WVALID_I(WVALID_I),
  .WREADY_O(WREADY_O), .W_I(W_I), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
  .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .AR_I(AR_I),
  .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .R_O(R_O), .WDOG_RESET_O(WDOG_RESET_O),
  .TIMER_IRQ_O(TIMER_IRQ_O));
